// *** logic/sid_driver.sv ***
// front-panel status indicator driver with register port and interrupt
//
// The plain strobed port and the register offsets are this design's own decisions.
`include "sid_params.svh"
module sid_driver #(
  parameter logic [`SID_TICK_W-1:0] TICK_CYCLES = `SID_TICK_W'(`SID_TICK_CYCLES)
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire logic [`SID_ADDR_W-1:0] addr,
  input wire logic [`SID_DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`SID_DATA_W-1:0] rd_data,
  output logic irq,
  // internal status
  input wire sid_pkg::sid_boot_e boot_stage,
  input wire sid_pkg::sid_slave_e slave_state,
  input wire logic cfg_err,
  input wire logic local_change,
  input wire logic host_wdg_expired,
  input wire logic sync_err,
  input wire logic app_wdg_expired,
  input wire logic modbus_frame,
  input wire logic alarm_active,
  input wire logic hw_fault,
  // state change requests
  output logic force_valid,
  output sid_pkg::sid_slave_e force_target,
  // lamps
  output logic system_stage_lamp_red,
  output logic system_stage_lamp_green,
  output logic bus_error_lamp,
  output logic run_lamp,
  output logic com_lamp,
  output logic supply_present_lamp,
  output logic process_alarm_lamp
);
  import sid_pkg::*;

  sid_pattern_if pat();

  sid_pattern #(.TICK_CYCLES(TICK_CYCLES)) u_pattern (
    .clk(clk),
    .resetn(resetn),
    .pat(pat)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  logic ctrl_reg;
  logic [`SID_NEVT-1:0] status_reg;
  logic [`SID_NEVT-1:0] mask_reg;
  logic [`SID_NEVT-1:0] evt;
  logic [`SID_NEVT-1:0] w1c;
  logic [1:0] com_hold_reg;
  logic pwr_reg;
  logic [6:0] lamps;

  assign evt[`SID_EVT_LOCAL] = local_change | host_wdg_expired | sync_err;
  assign evt[`SID_EVT_APPWDG] = app_wdg_expired;
  assign evt[`SID_EVT_CFG] = cfg_err;
  assign evt[`SID_EVT_ALARM] = alarm_active;
  assign evt[`SID_EVT_HWFAULT] = hw_fault;
  assign w1c = (wr_en && addr == `SID_OFF_STATUS) ? wr_data[`SID_NEVT-1:0] : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `SID_CTRL_RESET;
    end else if (wr_en && addr == `SID_OFF_CTRL) begin
      ctrl_reg <= wr_data[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mask_reg <= `SID_MASK_RESET;
    end else if (wr_en && addr == `SID_OFF_MASK) begin
      mask_reg <= wr_data[`SID_NEVT-1:0];
    end
  end

  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~w1c) | evt;
    end
  end

  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      if (addr == `SID_OFF_CTRL) begin
        rd_data <= {31'h0, ctrl_reg};
      end else if (addr == `SID_OFF_STATUS) begin
        rd_data <= {27'h0, status_reg};
      end else if (addr == `SID_OFF_MASK) begin
        rd_data <= {27'h0, mask_reg};
      end else if (addr == `SID_OFF_STATE) begin
        rd_data <= {17'h0, lamps, slave_state, boot_stage};
      end else begin
        rd_data <= '0;
      end
    end else begin
      rd_data <= '0;
    end
  end

  // ****************************************************************
  // state change requests
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      force_valid <= 1'b0;
      force_target <= SID_ST_INIT;
    end else begin
      force_valid <= sync_err | host_wdg_expired;
      if (sync_err) begin
        force_target <= SID_ST_SAFEOP;
      end else if (host_wdg_expired) begin
        case (slave_state)
          SID_ST_OP: force_target <= SID_ST_SAFEOP;
          SID_ST_SAFEOP: force_target <= SID_ST_PREOP;
          default: force_target <= SID_ST_INIT;
        endcase
      end
    end
  end

  // ****************************************************************
  // lamp patterns
  // ****************************************************************
  logic sys_red_next, sys_green_next, err_next, run_next, com_next, alm_next;
  logic local_err, app_err;

  assign local_err = status_reg[`SID_EVT_LOCAL];
  assign app_err = status_reg[`SID_EVT_APPWDG];

  always_comb begin
    sys_red_next = 1'b0;
    sys_green_next = 1'b0;
    case (boot_stage)
      SID_BOOT_RUN: sys_green_next = 1'b1;
      SID_BOOT_WAIT_FW: begin
        sys_red_next = pat.blink;
        sys_green_next = ~pat.blink;
      end
      SID_BOOT_LOADER: sys_red_next = 1'b1;
      default: sys_red_next = 1'b0;
    endcase
  end

  always_comb begin
    if (cfg_err) begin
      err_next = pat.blink;
    end else if (app_err) begin
      err_next = pat.dbl;
    end else if (local_err) begin
      err_next = pat.single;
    end else begin
      err_next = 1'b0;
    end
  end

  always_comb begin
    case (slave_state)
      SID_ST_PREOP: run_next = pat.blink;
      SID_ST_SAFEOP: run_next = pat.single;
      SID_ST_OP: run_next = 1'b1;
      default: run_next = 1'b0;
    endcase
  end

  always_comb begin
    if (hw_fault) begin
      alm_next = 1'b1;
    end else if (alarm_active) begin
      alm_next = pat.blink;
    end else begin
      alm_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      com_hold_reg <= '0;
    end else if (modbus_frame) begin
      com_hold_reg <= `SID_COM_HOLD;
    end else if (pat.tick && com_hold_reg != 2'h0) begin
      com_hold_reg <= com_hold_reg - 2'h1;
    end
  end
  assign com_next = (com_hold_reg != 2'h0) & pat.blink;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pwr_reg <= 1'b0;
    end else begin
      pwr_reg <= 1'b1;
    end
  end

  // lamps registered; ctrl bit 0 enables every lamp except supply_present_lamp
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      system_stage_lamp_red <= 1'b0;
      system_stage_lamp_green <= 1'b0;
      bus_error_lamp <= 1'b0;
      run_lamp <= 1'b0;
      com_lamp <= 1'b0;
      process_alarm_lamp <= 1'b0;
    end else begin
      system_stage_lamp_red <= ctrl_reg & sys_red_next;
      system_stage_lamp_green <= ctrl_reg & sys_green_next;
      bus_error_lamp <= ctrl_reg & err_next;
      run_lamp <= ctrl_reg & run_next;
      com_lamp <= ctrl_reg & com_next;
      process_alarm_lamp <= ctrl_reg & alm_next;
    end
  end
  assign supply_present_lamp = pwr_reg;
  assign lamps = {process_alarm_lamp, supply_present_lamp, com_lamp, run_lamp,
                  bus_error_lamp, system_stage_lamp_green, system_stage_lamp_red};

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_sync_seen;
    sync_err;
  endsequence
  sequence s_forced_safeop;
    ##1 force_valid && force_target == SID_ST_SAFEOP;
  endsequence

  a_sys_green: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && boot_stage == SID_BOOT_RUN |=> system_stage_lamp_green && !system_stage_lamp_red)
    else $error("system lamp not green while running");
  a_sys_alternate: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && boot_stage == SID_BOOT_WAIT_FW
      |=> system_stage_lamp_red != system_stage_lamp_green)
    else $error("system lamp not alternating");
  a_sys_red: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && boot_stage == SID_BOOT_LOADER |=> system_stage_lamp_red && !system_stage_lamp_green)
    else $error("system lamp not red in loader wait");
  a_err_cfg_blink: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && cfg_err |=> bus_error_lamp == $past(pat.blink))
    else $error("error lamp not blinking on configuration error");
  a_err_single: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && !cfg_err && !app_err && local_err |=> bus_error_lamp == $past(pat.single))
    else $error("error lamp not single flashing");
  a_wdg_leave: assert property (@(posedge clk) disable iff (!resetn)
    host_wdg_expired && !sync_err && slave_state == SID_ST_OP
      |=> force_valid && force_target == SID_ST_SAFEOP ##0 local_err)
    else $error("host watchdog did not leave operational");
  a_sync_safeop: assert property (@(posedge clk) disable iff (!resetn)
    s_sync_seen |-> s_forced_safeop ##0 status_reg[`SID_EVT_LOCAL])
    else $error("sync error not forcing safe-operational");
  a_err_double: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && !cfg_err && app_err |=> bus_error_lamp == $past(pat.dbl))
    else $error("error lamp not double flashing");
  a_err_dark: assert property (@(posedge clk) disable iff (!resetn)
    !cfg_err && !app_err && !local_err |=> !bus_error_lamp)
    else $error("error lamp lit without error");
  a_run_preop: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && slave_state == SID_ST_PREOP |=> run_lamp == $past(pat.blink))
    else $error("run lamp not blinking in pre-operational");
  a_run_states: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && slave_state != SID_ST_PREOP
      |=> run_lamp == ($past(slave_state) == SID_ST_OP
                       || ($past(slave_state) == SID_ST_SAFEOP && $past(pat.single))))
    else $error("run lamp wrong for state");
  a_com_dark: assert property (@(posedge clk) disable iff (!resetn)
    com_hold_reg == 2'h0 && !modbus_frame |=> !com_lamp [*2])
    else $error("communication lamp lit without traffic");
  a_pwr_lit: assert property (@(posedge clk) disable iff (!resetn)
    $past(resetn) |-> supply_present_lamp)
    else $error("supply lamp went dark");
  a_alm_blink: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && alarm_active && !hw_fault |=> process_alarm_lamp == $past(pat.blink))
    else $error("alarm lamp not blinking");
  a_alm_hw: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_reg && hw_fault |=> process_alarm_lamp)
    else $error("alarm lamp not steady on hardware fault");
  a_alm_dark: assert property (@(posedge clk) disable iff (!resetn)
    !hw_fault && !alarm_active |=> !process_alarm_lamp)
    else $error("alarm lamp lit without alarm");
endmodule // sid_driver

// *** logic/sid_params.svh ***
// constants of the status indicator driver
`ifndef SID_PARAMS_SVH
`define SID_PARAMS_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SID_CLK_KHZ 100000
`define SID_FLASH_MS 200
`define SID_TICK_W 25
`define SID_TICK_CYCLES (`SID_FLASH_MS * `SID_CLK_KHZ)
`define SID_PHASE_W 3
`define SID_COM_HOLD 2'h3

// ****************************************************************
// register map
// ****************************************************************
`define SID_ADDR_W 8
`define SID_DATA_W 32
`define SID_OFF_CTRL 8'h00
`define SID_OFF_STATUS 8'h04
`define SID_OFF_MASK 8'h08
`define SID_OFF_STATE 8'h0c
`define SID_CTRL_RESET 1'h1
`define SID_MASK_RESET 5'h00

// ****************************************************************
// status fields
// ****************************************************************
`define SID_NEVT 5
`define SID_EVT_LOCAL 0
`define SID_EVT_APPWDG 1
`define SID_EVT_CFG 2
`define SID_EVT_ALARM 3
`define SID_EVT_HWFAULT 4

`endif

// *** logic/sid_pkg.sv ***
// types of the status indicator driver
package sid_pkg;
  typedef enum logic [3:0] {
    SID_BOOT_OFF = 4'h1,
    SID_BOOT_LOADER = 4'h2,
    SID_BOOT_WAIT_FW = 4'h4,
    SID_BOOT_RUN = 4'h8
  } sid_boot_e;
  typedef enum logic [3:0] {
    SID_ST_INIT = 4'h1,
    SID_ST_PREOP = 4'h2,
    SID_ST_SAFEOP = 4'h4,
    SID_ST_OP = 4'h8
  } sid_slave_e;
endpackage

// *** logic/sid_pattern_if.sv ***
// flash patterns passed from the pattern generator to the driver
interface sid_pattern_if;
  logic blink;
  logic single;
  logic dbl;
  logic tick;
  modport gen (output blink, output single, output dbl, output tick);
  modport use_p (input blink, input single, input dbl, input tick);
endinterface

// *** logic/sid_pattern.sv ***
// flash pattern generator: 2.5 Hz blink, single and double flash
`include "sid_params.svh"
module sid_pattern #(
  parameter logic [`SID_TICK_W-1:0] TICK_CYCLES = `SID_TICK_W'(`SID_TICK_CYCLES)
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // patterns
  sid_pattern_if.gen pat
);
  logic [`SID_TICK_W-1:0] cnt_reg;
  logic [`SID_PHASE_W-1:0] phase_reg;
  logic tick;

  assign tick = (cnt_reg == TICK_CYCLES - `SID_TICK_W'(1));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
    end else if (tick) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + `SID_TICK_W'(1);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= '0;
    end else if (tick) begin
      phase_reg <= phase_reg + `SID_PHASE_W'(1);
    end
  end

  assign pat.tick = tick;
  assign pat.blink = ~phase_reg[0];
  assign pat.single = (phase_reg == 3'h0);
  assign pat.dbl = (phase_reg == 3'h0) || (phase_reg == 3'h2);

  a_phase_steps: assert property (@(posedge clk) disable iff (!resetn)
    tick |=> phase_reg == $past(phase_reg) + 3'h1)
    else $error("phase did not advance on tick");
  a_phase_hold: assert property (@(posedge clk) disable iff (!resetn)
    !tick |=> $stable(phase_reg))
    else $error("phase moved without tick");
endmodule // sid_pattern

// *** dv/sid_operator.sv ***
// operator model: counts lit cycles of each front-panel lamp
module sid_operator (
  // clock
  input wire logic clk,
  // observation window
  input wire logic clr,
  input wire logic [6:0] lamp,
  output logic [5:0] lit [7]
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // lit-cycle counters, restarted by clr
  // ****************************************************************
  always_ff @(posedge clk) begin
    for (int i = 0; i < 7; i++) begin
      lit[i] <= clr ? 6'h00 : lit[i] + 6'(lamp[i]);
    end
  end
endmodule // sid_operator

// *** dv/test_status_indicator_driver.sv ***
// self-checking bench of the status indicator driver
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module test_status_indicator_driver;
  timeunit 1ns;
  timeprecision 100ps;
  import sid_pkg::*;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_en = 1'h0;
  logic rd_en = 1'h0;
  logic [31:0] rd_data, d, v;
  logic irq, force_valid;
  sid_slave_e force_target;
  sid_boot_e boot_stage = SID_BOOT_OFF;
  sid_slave_e slave_state = SID_ST_INIT;
  logic cfg_err = 1'h0, local_change = 1'h0, host_wdg_expired = 1'h0;
  logic sync_err = 1'h0, app_wdg_expired = 1'h0, modbus_frame = 1'h0;
  logic alarm_active = 1'h0, hw_fault = 1'h0, clr = 1'h0;
  logic [6:0] lamp;
  logic [5:0] lit [7];
  logic [7:0] a;
  int n_fail = 0, n_compared = 0, r;
  sid_boot_e bt [4] = '{SID_BOOT_OFF, SID_BOOT_LOADER, SID_BOOT_WAIT_FW, SID_BOOT_RUN};
  sid_slave_e ss [4] = '{SID_ST_INIT, SID_ST_PREOP, SID_ST_SAFEOP, SID_ST_OP};
  always #5 clk = ~clk;
  // short tick: one 8-phase pattern period is 32 cycles
  sid_driver #(.TICK_CYCLES(25'h4)) dut (.clk(clk), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .boot_stage(boot_stage), .slave_state(slave_state), .cfg_err(cfg_err),
    .local_change(local_change), .host_wdg_expired(host_wdg_expired),
    .sync_err(sync_err), .app_wdg_expired(app_wdg_expired),
    .modbus_frame(modbus_frame), .alarm_active(alarm_active), .hw_fault(hw_fault),
    .force_valid(force_valid), .force_target(force_target),
    .system_stage_lamp_red(lamp[0]), .system_stage_lamp_green(lamp[1]),
    .bus_error_lamp(lamp[2]), .run_lamp(lamp[3]), .com_lamp(lamp[4]),
    .supply_present_lamp(lamp[5]), .process_alarm_lamp(lamp[6]));
  sid_operator op (.clk(clk), .clr(clr), .lamp(lamp), .lit(lit));
  // ****************************************************************
  // bus tasks and expectations
  // ****************************************************************
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge clk);
    addr <= ad;
    wr_data <= v;
    wr_en <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] ad);
    @(posedge clk);
    addr <= ad;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1 d = rd_data;
  endtask
  // lit cycles over exactly one pattern period
  task automatic watch();
    repeat (8) @(posedge clk);
    clr <= 1'h1;
    @(posedge clk);
    clr <= 1'h0;
    repeat (32) @(posedge clk);
    #1;
  endtask
  task automatic kick(input logic host, input sid_slave_e st, input sid_slave_e tgt);
    @(posedge clk);
    slave_state <= st;
    host_wdg_expired <= host;
    sync_err <= !host;
    @(posedge clk);
    host_wdg_expired <= 1'h0;
    sync_err <= 1'h0;
    #1 `CHK(force_valid, 1'h1)
    `CHK(force_target, tgt)
    @(posedge clk);
    #1 `CHK(force_valid, 1'h0)
  endtask
  function automatic logic [5:0] run_exp(sid_slave_e s);
    case (s)
      SID_ST_PREOP: return 6'h10;
      SID_ST_SAFEOP: return 6'h04;
      SID_ST_OP: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction
  // {red, green} lit cycles
  function automatic logic [11:0] sys_exp(sid_boot_e b);
    case (b)
      SID_BOOT_LOADER: return 12'h800;
      SID_BOOT_WAIT_FW: return 12'h410;
      SID_BOOT_RUN: return 12'h020;
      default: return 12'h000;
    endcase
  endfunction
  task automatic test_done();
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    n_fail++;
    test_done();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'h0684));
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    rd(8'h00);
    `CHK(d, 32'h1)
    rd(8'h08);
    `CHK(d, 32'h0)
    a = 8'($urandom_range(255, 16));
    wr(a, $urandom);
    rd(a);
    `CHK(d, 32'h0)
    v = $urandom;
    wr(8'h08, v);
    rd(8'h08);
    `CHK(d, {27'h0, v[4:0]})
    r = $urandom_range(3, 0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      boot_stage <= bt[(i + r) % 4];
      slave_state <= ss[(i + r) % 4];
      watch();
      `CHK({lit[0], lit[1]}, sys_exp(bt[(i + r) % 4]))
      `CHK(lit[3], run_exp(ss[(i + r) % 4]))
      `CHK(lit[5], 6'h20)
    end
    @(posedge clk);
    boot_stage <= SID_BOOT_RUN;
    slave_state <= SID_ST_OP;
    repeat (2) @(posedge clk);
    rd(8'h0c);
    `CHK(d, 32'h2a88)
    wr(8'h00, 32'h0);
    watch();
    `CHK(lit[1] | lit[3], 6'h00)
    `CHK(lit[5], 6'h20)
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h0);
    wr(8'h04, 32'h1f);
    kick(1'h0, SID_ST_OP, SID_ST_SAFEOP);
    kick(1'h1, SID_ST_OP, SID_ST_SAFEOP);
    kick(1'h1, SID_ST_SAFEOP, SID_ST_PREOP);
    kick(1'h1, SID_ST_INIT, SID_ST_INIT);
    kick(1'h0, SID_ST_PREOP, SID_ST_SAFEOP);
    `CHK(irq, 1'h0)
    rd(8'h04);
    `CHK(d, 32'h1)
    wr(8'h08, 32'h1);
    #1 `CHK(irq, 1'h1)
    wr(8'h04, 32'h1);
    #1 `CHK(irq, 1'h0)
    @(posedge clk);
    cfg_err <= 1'h1;
    app_wdg_expired <= 1'h1;
    local_change <= 1'h1;
    @(posedge clk);
    app_wdg_expired <= 1'h0;
    local_change <= 1'h0;
    watch();
    `CHK(lit[2], 6'h10)
    rd(8'h04);
    `CHK(d, 32'h7)
    @(posedge clk);
    cfg_err <= 1'h0;
    watch();
    `CHK(lit[2], 6'h08)
    wr(8'h04, 32'h6);
    watch();
    `CHK(lit[2], 6'h04)
    wr(8'h04, 32'h1);
    watch();
    `CHK(lit[2], 6'h00)
    @(posedge clk);
    alarm_active <= 1'h1;
    watch();
    `CHK(lit[6], 6'h10)
    @(posedge clk);
    hw_fault <= 1'h1;
    watch();
    `CHK(lit[6], 6'h20)
    @(posedge clk);
    alarm_active <= 1'h0;
    hw_fault <= 1'h0;
    watch();
    `CHK(lit[6], 6'h00)
    @(posedge clk);
    modbus_frame <= 1'h1;
    watch();
    `CHK(lit[4], 6'h10)
    @(posedge clk);
    modbus_frame <= 1'h0;
    repeat (16) @(posedge clk);
    watch();
    `CHK(lit[4], 6'h00)
    test_done();
  end
endmodule // test_status_indicator_driver
